// ---- rtl/watchdog_pkg.sv ----
package watchdog_pkg;

	// ****************************************************************
	// Register map, byte addresses on the APB.
	// ****************************************************************
	localparam logic [7:0] CTRL_STATUS_OFFSET  = 8'h00;
	localparam logic [7:0] RELOAD_UPPER_OFFSET = 8'h04;
	localparam logic [7:0] RELOAD_HIGH_OFFSET  = 8'h08;
	localparam logic [7:0] RELOAD_LOW_OFFSET   = 8'h0C;
	localparam logic [7:0] OPTION_OFFSET       = 8'h10;
	localparam logic [7:0] COUNT_OFFSET        = 8'h14;

	// ****************************************************************
	// Field positions.
	// ****************************************************************
	localparam int POWER_ON_BIT      = 7;
	localparam int STOP_RECOVERY_BIT = 6;
	localparam int TIMEOUT_BIT       = 5;
	localparam int EXT_RESET_BIT     = 4;
	localparam int STOP_DISABLE_BIT  = 0;
	localparam int ALWAYS_ON_BIT     = 0;
	localparam int RESPONSE_BIT      = 1;

	// ****************************************************************
	// Reset values.
	// ****************************************************************
	localparam logic [3:0]  STATUS_RESET       = 4'h8;
	localparam logic [23:0] RELOAD_RESET       = 24'h000400;
	localparam logic        ALWAYS_ON_RESET    = 1'b0;
	localparam logic        RESPONSE_RESET     = 1'b0;
	localparam logic        STOP_DISABLE_RESET = 1'b0;

	// ****************************************************************
	// Unlock sequence codes and counter limits.
	// ****************************************************************
	localparam logic [7:0]  UNLOCK_FIRST      = 8'h55;
	localparam logic [7:0]  UNLOCK_SECOND     = 8'hAA;
	localparam logic [7:0]  STOP_OFF_CODE     = 8'h81;
	localparam logic [7:0]  STOP_ON_CODE      = 8'h00;
	localparam logic [23:0] REFRESH_LIMIT     = 24'h000002;
	localparam logic [23:0] COUNT_MAX         = 24'hFFFFFF;
	localparam logic [23:0] COUNT_LAST        = 24'h000001;
	localparam int          RC_OSC_FREQ_HZ    = 10000;

	// ****************************************************************
	// Lock state machine.
	// ****************************************************************
	typedef enum logic [2:0]
	{
		LOCKED,
		GOT_FIRST,
		GOT_SECOND,
		WANT_HIGH,
		WANT_LOW
	} lock_state_type;

endpackage

// ---- rtl/watchdog_counter.sv ----
`timescale 1ns/1ps

// ****************************************************************
// 24-bit down-counter with load, wrap and expiry pulse.
// ****************************************************************
module watchdog_counter
(
	// Clock and reset.
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Control.
	input  wire logic        load,
	input  wire logic [23:0] load_value,
	input  wire logic        step,
	// Status.
	output logic      [23:0] count_r,
	output logic             expire_r
);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			count_r <= watchdog_pkg::COUNT_MAX;
		else if (load)
			count_r <= load_value;                                   // [R7] [R8]
		else if (step && count_r == 24'h000000)
			count_r <= watchdog_pkg::COUNT_MAX;                      // [R12]
		else if (step)
			count_r <= count_r - 24'h000001;                         // [R1]
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			expire_r <= 1'b0;
		else
			expire_r <= !load && step && count_r == watchdog_pkg::COUNT_LAST; // [R10]
	end

	a_wrap_at_zero: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
		!load && step && count_r == 24'h000000 |=> count_r == watchdog_pkg::COUNT_MAX)
		else $error("counter did not wrap to its maximum");

	a_expire_at_zero: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
		expire_r |-> count_r == 24'h000000)
		else $error("expiry flagged while counter not zero");

endmodule

// ---- rtl/watchdog_timer_24bit.sv ----
`timescale 1ns/1ps

// Summary of operation
// R1: Watchdog is a 24-bit down-counter reloaded from a programmable value.
// R2: Counter advances only on rising edges of its own RC oscillator.
// R3: Enabled by refresh instruction or always-on option; then counts forever.
// R4: Reload value is upper, high, low bytes concatenated, upper most significant.
// R5: Refresh requests are ignored once the counter is at two or below.
// R6: Software never programs a reload value below four.
// R7: On first enable the counter loads the reload value, then counts down.
// R8: Each refresh reloads the counter with the current reload value.
// R9: In debug mode the counter is reloaded continuously, so never times out.
// R10: Time-out when counter reaches zero; response option picks interrupt or reset.
// R11: Interrupt response in normal mode raises interrupt and sets time-out bit.
// R12: After interrupt time-out the counter wraps to maximum and keeps counting.
// R13: Interrupt response in stop mode: recovery, interrupt, time-out and stop bits.
// R14: Reset response in normal mode forces reset and sets time-out bit.
// R15: Reset response in stop mode: recovery instead of reset, both bits set.
// R16: By default watchdog and oscillator keep running in stop mode.
// R17: Writing 55h, AAh, 81h to control stops the watchdog during stop mode.
// R18: Writing 00h as the third step keeps it running during stop mode.
// R19: The stop setting only changes behaviour while in stop mode.
// R20: Unlock writes to the control address leave status bits unchanged.
// R21: Reload bytes accept writes only after 55h, AAh, then upper, high, low.
// R22: Any other write inside the sequence returns the lock to its start.
// R23: Reading the control/status register clears its upper four bits.
// R24: Power-on bit clears on a time-out or a stop-mode recovery.
// R25: After the low byte write the lock returns to locked.

module watchdog_timer_24bit
(
	// Clock and reset.
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave.
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// CPU and system side.
	input  wire logic        rc_osc_clk,
	input  wire logic        refresh_req,
	input  wire logic        debug_mode,
	input  wire logic        stop_mode,
	input  wire logic        ext_reset_seen,
	// Time-out responses.
	output logic             irq_req,
	output logic             reset_req,
	output logic             stop_recovery_req
);

	// ****************************************************************
	// State.
	// ****************************************************************
	logic [7:0]                  reload_upper_byte_r;
	logic [7:0]                  reload_high_byte_r;
	logic [7:0]                  reload_low_byte_r;
	logic [3:0]                  status_r;
	logic                        always_on_option_r;
	logic                        timeout_response_option_r;
	logic                        stop_disable_r;
	logic                        enabled_r;
	logic                        rc_prev_r;
	watchdog_pkg::lock_state_type lock_r;
	watchdog_pkg::lock_state_type lock_nxt;
	logic [23:0]                 count;
	logic                        expire;
	logic                        rc_tick;
	logic                        frozen;
	logic                        enable_now;
	logic                        load;
	logic                        step;
	logic                        wr_done;
	logic                        rd_done;
	logic                        ctrl_wr;
	logic [7:0]                  wbyte;
	logic [3:0]                  status_set;
	logic [3:0]                  status_clr;

	function automatic logic mapped(input logic [7:0] addr);
		mapped = addr == watchdog_pkg::CTRL_STATUS_OFFSET
			|| addr == watchdog_pkg::RELOAD_UPPER_OFFSET
			|| addr == watchdog_pkg::RELOAD_HIGH_OFFSET
			|| addr == watchdog_pkg::RELOAD_LOW_OFFSET
			|| addr == watchdog_pkg::OPTION_OFFSET
			|| addr == watchdog_pkg::COUNT_OFFSET;
	endfunction

	// ****************************************************************
	// APB handshake: one wait-free access cycle after setup.
	// ****************************************************************
	assign wr_done = psel && penable && pready && pwrite;
	assign rd_done = psel && penable && pready && !pwrite;
	assign wbyte   = pwdata[7:0];
	assign ctrl_wr = wr_done && paddr == watchdog_pkg::CTRL_STATUS_OFFSET;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pready <= 1'b0;
		else
			pready <= psel && !penable;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pslverr <= 1'b0;
		else
			pslverr <= psel && !penable && !mapped(paddr);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (psel && !penable && !pwrite)
		begin
			case (paddr)
				watchdog_pkg::CTRL_STATUS_OFFSET:
					prdata <= {24'h000000, status_r, 3'h0, stop_disable_r};
				watchdog_pkg::RELOAD_UPPER_OFFSET:
					prdata <= {24'h000000, reload_upper_byte_r};
				watchdog_pkg::RELOAD_HIGH_OFFSET:
					prdata <= {24'h000000, reload_high_byte_r};
				watchdog_pkg::RELOAD_LOW_OFFSET:
					prdata <= {24'h000000, reload_low_byte_r};
				watchdog_pkg::OPTION_OFFSET:
					prdata <= {30'h00000000, timeout_response_option_r,
						always_on_option_r};
				watchdog_pkg::COUNT_OFFSET:
					prdata <= {8'h00, count};
				default:
					prdata <= 32'h00000000;
			endcase
		end
	end

	// ****************************************************************
	// Lock state machine for reload and stop-mode setting.
	// ****************************************************************
	always_comb
	begin
		lock_nxt = lock_r;
		if (wr_done)
		begin
			case (lock_r)
				watchdog_pkg::LOCKED:
					lock_nxt = (ctrl_wr && wbyte == watchdog_pkg::UNLOCK_FIRST)
						? watchdog_pkg::GOT_FIRST : watchdog_pkg::LOCKED;
				watchdog_pkg::GOT_FIRST:
					lock_nxt = (ctrl_wr && wbyte == watchdog_pkg::UNLOCK_SECOND)
						? watchdog_pkg::GOT_SECOND : watchdog_pkg::LOCKED; // [R22]
				watchdog_pkg::GOT_SECOND:
					lock_nxt = (paddr == watchdog_pkg::RELOAD_UPPER_OFFSET)
						? watchdog_pkg::WANT_HIGH : watchdog_pkg::LOCKED; // [R21] [R22]
				watchdog_pkg::WANT_HIGH:
					lock_nxt = (paddr == watchdog_pkg::RELOAD_HIGH_OFFSET)
						? watchdog_pkg::WANT_LOW : watchdog_pkg::LOCKED; // [R22]
				watchdog_pkg::WANT_LOW:
					lock_nxt = watchdog_pkg::LOCKED;                 // [R25]
				default:
					lock_nxt = watchdog_pkg::LOCKED;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			lock_r <= watchdog_pkg::LOCKED;
		else
			lock_r <= lock_nxt;
	end

	// ****************************************************************
	// Reload bytes, written only in sequence.
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			reload_upper_byte_r <= watchdog_pkg::RELOAD_RESET[23:16];
			reload_high_byte_r  <= watchdog_pkg::RELOAD_RESET[15:8];
			reload_low_byte_r   <= watchdog_pkg::RELOAD_RESET[7:0];
		end
		else if (wr_done)
		begin
			if (lock_r == watchdog_pkg::GOT_SECOND
				&& paddr == watchdog_pkg::RELOAD_UPPER_OFFSET)
				reload_upper_byte_r <= wbyte;                       // [R21]
			if (lock_r == watchdog_pkg::WANT_HIGH
				&& paddr == watchdog_pkg::RELOAD_HIGH_OFFSET)
				reload_high_byte_r <= wbyte;                        // [R21]
			if (lock_r == watchdog_pkg::WANT_LOW
				&& paddr == watchdog_pkg::RELOAD_LOW_OFFSET)
				reload_low_byte_r <= wbyte;                         // [R21]
		end
	end

	// ****************************************************************
	// Stop-mode setting, third step after the unlock pair.
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			stop_disable_r <= watchdog_pkg::STOP_DISABLE_RESET;     // [R16]
		else if (ctrl_wr && lock_r == watchdog_pkg::GOT_SECOND)
		begin
			if (wbyte == watchdog_pkg::STOP_OFF_CODE)
				stop_disable_r <= 1'b1;                             // [R17]
			else if (wbyte == watchdog_pkg::STOP_ON_CODE)
				stop_disable_r <= 1'b0;                             // [R18]
		end
	end

	// ****************************************************************
	// Option bits.
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			always_on_option_r        <= watchdog_pkg::ALWAYS_ON_RESET;
			timeout_response_option_r <= watchdog_pkg::RESPONSE_RESET;
		end
		else if (wr_done && paddr == watchdog_pkg::OPTION_OFFSET)
		begin
			always_on_option_r        <= pwdata[watchdog_pkg::ALWAYS_ON_BIT];
			timeout_response_option_r <= pwdata[watchdog_pkg::RESPONSE_BIT];
		end
	end

	// ****************************************************************
	// Enable, RC tick and counter control.
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rc_prev_r <= 1'b0;
		else
			rc_prev_r <= rc_osc_clk;
	end

	assign rc_tick    = rc_osc_clk && !rc_prev_r;                    // [R2]
	assign frozen     = stop_mode && stop_disable_r;                 // [R19]
	assign enable_now = refresh_req || always_on_option_r;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			enabled_r <= 1'b0;
		else if (enable_now)
			enabled_r <= 1'b1;                                      // [R3]
	end

	// Load on first enable, in debug, or on a refresh above the limit.
	assign load = (!enabled_r && enable_now)                         // [R7]
		|| (enabled_r && debug_mode)                                // [R9]
		|| (enabled_r && refresh_req && count > watchdog_pkg::REFRESH_LIMIT); // [R5] [R8]
	assign step = enabled_r && rc_tick && !frozen;                   // [R3] [R16]

	watchdog_counter u_counter
	(
		.pclk       (pclk),
		.presetn    (presetn),
		.load       (load),
		.load_value ({reload_upper_byte_r, reload_high_byte_r, reload_low_byte_r}), // [R4]
		.step       (step),
		.count_r    (count),
		.expire_r   (expire)
	);

	// ****************************************************************
	// Time-out responses.
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_req           <= 1'b0;
			reset_req         <= 1'b0;
			stop_recovery_req <= 1'b0;
		end
		else
		begin
			irq_req           <= expire && !timeout_response_option_r;   // [R11] [R13]
			reset_req         <= expire && timeout_response_option_r
				&& !stop_mode;                                          // [R14]
			stop_recovery_req <= expire && stop_mode;                   // [R13] [R15]
		end
	end

	// ****************************************************************
	// Status bits: set wins over read-clear.
	// ****************************************************************
	always_comb
	begin
		status_set = 4'h0;
		status_clr = 4'h0;
		if (expire)
		begin
			status_set[watchdog_pkg::TIMEOUT_BIT - 4] = 1'b1;        // [R11] [R14]
			status_clr[watchdog_pkg::POWER_ON_BIT - 4] = 1'b1;       // [R24]
			if (stop_mode)
				status_set[watchdog_pkg::STOP_RECOVERY_BIT - 4] = 1'b1; // [R13] [R15]
			else
				status_clr[watchdog_pkg::STOP_RECOVERY_BIT - 4] = 1'b1;
		end
		if (ext_reset_seen)
			status_set[watchdog_pkg::EXT_RESET_BIT - 4] = 1'b1;
		if (rd_done && paddr == watchdog_pkg::CTRL_STATUS_OFFSET)
			status_clr = status_clr | prdata[7:4];                      // [R23]
	end

	// Control-address writes never touch the status bits.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			status_r <= watchdog_pkg::STATUS_RESET;
		else
			status_r <= (status_r & ~status_clr) | status_set;          // [R20]
	end

	// ****************************************************************
	// Checks.
	// ****************************************************************
	a_refresh_ignored: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
		enabled_r && refresh_req && !debug_mode && count <= watchdog_pkg::REFRESH_LIMIT
		&& !step |=> count == $past(count))
		else $error("refresh reloaded a counter at or below two");

	a_refresh_reload: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
		enabled_r && refresh_req && count > watchdog_pkg::REFRESH_LIMIT
		|=> count == {reload_upper_byte_r, reload_high_byte_r, reload_low_byte_r})
		else $error("refresh did not reload the counter");

	a_first_enable: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
		!enabled_r && always_on_option_r |=> enabled_r
		&& count == $past({reload_upper_byte_r, reload_high_byte_r, reload_low_byte_r}))
		else $error("first enable did not load the reload value");

	a_debug_no_timeout: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
		enabled_r && debug_mode ##1 debug_mode |=> !expire)
		else $error("time-out while in debug mode");

	a_irq_response: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
		expire && !timeout_response_option_r |=> irq_req && !reset_req
		&& status_r[watchdog_pkg::TIMEOUT_BIT - 4])
		else $error("interrupt response missing");

	a_reset_response: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
		expire && timeout_response_option_r && !stop_mode |=> reset_req && !irq_req)
		else $error("reset response missing");

	a_stop_recovery: assert property (@(posedge pclk) disable iff (!presetn) // [R15]
		expire && stop_mode |=> stop_recovery_req && !reset_req
		&& status_r[watchdog_pkg::STOP_RECOVERY_BIT - 4]
		&& !status_r[watchdog_pkg::POWER_ON_BIT - 4])
		else $error("stop-mode recovery response missing");

	a_frozen_in_stop: assert property (@(posedge pclk) disable iff (!presetn) // [R17]
		frozen && !load |=> count == $past(count))
		else $error("counter moved while stopped in stop mode");

	a_stop_setting: assert property (@(posedge pclk) disable iff (!presetn) // [R17]
		ctrl_wr && lock_r == watchdog_pkg::GOT_SECOND
		&& wbyte == watchdog_pkg::STOP_OFF_CODE |=> stop_disable_r)
		else $error("stop-mode disable code not taken");

	a_locked_reload: assert property (@(posedge pclk) disable iff (!presetn) // [R21]
		wr_done && paddr == watchdog_pkg::RELOAD_UPPER_OFFSET
		&& lock_r != watchdog_pkg::GOT_SECOND |=> $stable(reload_upper_byte_r))
		else $error("reload byte written while locked");

	a_relock_after_low: assert property (@(posedge pclk) disable iff (!presetn) // [R25]
		wr_done && lock_r == watchdog_pkg::WANT_LOW |=> lock_r == watchdog_pkg::LOCKED)
		else $error("lock did not return after low byte");

	a_read_clears: assert property (@(posedge pclk) disable iff (!presetn) // [R23]
		rd_done && paddr == watchdog_pkg::CTRL_STATUS_OFFSET && !expire
		&& !ext_reset_seen |=> status_r == 4'h0)
		else $error("status read did not clear upper bits");

	c_irq_timeout: cover property (@(posedge pclk) disable iff (!presetn)
		expire && !timeout_response_option_r);
	c_reset_timeout: cover property (@(posedge pclk) disable iff (!presetn)
		expire && timeout_response_option_r && !stop_mode);
	c_stop_timeout: cover property (@(posedge pclk) disable iff (!presetn)
		expire && stop_mode);
	c_reload_written: cover property (@(posedge pclk) disable iff (!presetn)
		wr_done && lock_r == watchdog_pkg::WANT_LOW
		&& paddr == watchdog_pkg::RELOAD_LOW_OFFSET);

endmodule

// ---- sim/watchdog_partner.sv ----
`timescale 1ns/1ps

// ****************************************************************
// Model of the CPU, interrupt controller and reset logic.
// ****************************************************************
module watchdog_partner
(
	// Clock.
	input  wire logic pclk,
	// Towards the watchdog.
	output logic      rc_osc_clk,
	output logic      refresh_req,
	output logic      debug_mode,
	output logic      stop_mode,
	output logic      ext_reset_seen,
	// Time-out responses.
	input  wire logic irq_req,
	input  wire logic reset_req,
	input  wire logic stop_recovery_req
);
	int n_irq = 0;
	int n_rst = 0;
	int n_stop = 0;

	initial
	begin
		rc_osc_clk = 1'b0;
		refresh_req = 1'b0;
		debug_mode = 1'b0;
		stop_mode = 1'b0;
		ext_reset_seen = 1'b0;
	end

	always @(posedge pclk)
	begin
		n_irq <= n_irq + int'(irq_req === 1'b1);
		n_rst <= n_rst + int'(reset_req === 1'b1);
		n_stop <= n_stop + int'(stop_recovery_req === 1'b1);
	end

	// The oscillator runs six times slower than the bus clock: three cycles high, three low.
	task automatic tick(input int n);
		repeat (n)
		begin
			rc_osc_clk <= 1'b1;
			repeat (3) @(posedge pclk);
			rc_osc_clk <= 1'b0;
			repeat (3) @(posedge pclk);
		end
	endtask

	// One refresh instruction lasts one cycle.
	task automatic refresh();
		refresh_req <= 1'b1;
		@(posedge pclk);
		refresh_req <= 1'b0;
		@(posedge pclk);
	endtask

	// Debug and stop are levels, the reset indicator a pulse.
	task automatic mode(input logic d, input logic s, input logic x);
		debug_mode <= d;
		stop_mode <= s;
		ext_reset_seen <= x;
		@(posedge pclk);
		ext_reset_seen <= 1'b0;
		@(posedge pclk);
	endtask
endmodule

// ---- sim/watchdog_timer_24bit_test.sv ----
`timescale 1ns/1ps

module watchdog_timer_24bit_test;
	localparam logic [7:0] A_CS = watchdog_pkg::CTRL_STATUS_OFFSET;
	localparam logic [7:0] A_UP = watchdog_pkg::RELOAD_UPPER_OFFSET;
	localparam logic [7:0] A_HI = watchdog_pkg::RELOAD_HIGH_OFFSET;
	localparam logic [7:0] A_LO = watchdog_pkg::RELOAD_LOW_OFFSET;
	localparam logic [7:0] A_OP = watchdog_pkg::OPTION_OFFSET;
	localparam logic [7:0] A_CN = watchdog_pkg::COUNT_OFFSET;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        rc_osc_clk, refresh_req, debug_mode, stop_mode, ext_reset_seen;
	logic        irq_req, reset_req, stop_recovery_req;
	logic [31:0] seed = 32'h626C8B8F;
	logic [31:0] rd;
	logic        er;
	logic [7:0]  u, h, l;
	int          failures = 0;
	int          checks = 0;

	watchdog_timer_24bit u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rc_osc_clk(rc_osc_clk),
		.refresh_req(refresh_req), .debug_mode(debug_mode), .stop_mode(stop_mode),
		.ext_reset_seen(ext_reset_seen), .irq_req(irq_req), .reset_req(reset_req),
		.stop_recovery_req(stop_recovery_req));
	watchdog_partner u_cpu (.pclk(pclk), .rc_osc_clk(rc_osc_clk),
		.refresh_req(refresh_req), .debug_mode(debug_mode), .stop_mode(stop_mode),
		.ext_reset_seen(ext_reset_seen), .irq_req(irq_req), .reset_req(reset_req),
		.stop_recovery_req(stop_recovery_req));

	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	function automatic logic [7:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[7:0];
	endfunction

	task automatic tally_and_finish();
		$display("TB: checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e)
		begin
			failures++;
			$display("Error t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 16)
		begin
			failures++;
			tally_and_finish();
		end
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask

	task automatic unlock();
		apb(1'b1, A_CS, 32'h55);
		apb(1'b1, A_CS, 32'hAA);
	endtask

	task automatic load(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
		unlock();
		apb(1'b1, A_UP, {24'h0, a});
		apb(1'b1, A_HI, {24'h0, b});
		apb(1'b1, A_LO, {24'h0, c});
	endtask

	task automatic tmo(input logic [31:0] op, input logic s, input int ei, input int eo,
		input int es, input logic [31:0] st);
		int a;
		int b;
		int c;
		logic x;
		x = ^rnd();
		apb(1'b1, A_OP, op);
		u_cpu.mode(1'b0, s, x);
		u_cpu.refresh();
		a = u_cpu.n_irq;
		b = u_cpu.n_rst;
		c = u_cpu.n_stop;
		u_cpu.tick(int'(l));
		chk(32'(u_cpu.n_irq - a), 32'(ei));
		chk(32'(u_cpu.n_rst - b), 32'(eo));
		chk(32'(u_cpu.n_stop - c), 32'(es));
		rdchk(A_CS, st | {27'h0, x, 4'h0});
		u_cpu.tick(1);
	endtask

	initial
	begin
		presetn <= 1'b0;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 8'h00;
		pwdata <= 32'h0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rdchk(A_CS, 32'h80);
		rdchk(A_CS, 32'h00);
		rdchk(A_HI, 32'h04);
		rdchk(A_CN, 32'hFFFFFF);
		apb(1'b0, 8'h18, 32'h0);
		chk({31'h0, er}, 32'h1);
		apb(1'b1, A_UP, {24'h0, rnd()});
		rdchk(A_UP, 32'h00);
		apb(1'b1, A_CS, 32'h55);
		apb(1'b1, A_OP, 32'h00);
		apb(1'b1, A_CS, 32'hAA);
		apb(1'b1, A_UP, 32'h11);
		rdchk(A_UP, 32'h00);
		rdchk(A_CS, 32'h00);
		u = rnd() | 8'h01;
		h = rnd();
		l = rnd();
		load(u, h, l);
		rdchk(A_UP, {24'h0, u});
		apb(1'b1, A_LO, {24'h0, ~l});
		rdchk(A_LO, {24'h0, l});
		u_cpu.refresh();
		rdchk(A_CN, {8'h0, u, h, l});
		u_cpu.tick(3);
		rdchk(A_CN, {8'h0, u, h, l} - 32'h3);
		l = 8'h04 + (rnd() & 8'h07); // The reload never goes below four.
		load(8'h00, 8'h00, l);
		u_cpu.refresh();
		rdchk(A_CN, {24'h0, l});
		u_cpu.mode(1'b1, 1'b0, 1'b0);
		u_cpu.tick(5);
		rdchk(A_CN, {24'h0, l});
		u_cpu.mode(1'b0, 1'b0, 1'b0);
		u_cpu.tick(int'(l) - 2);
		u_cpu.refresh();
		rdchk(A_CN, 32'h2);
		u_cpu.tick(2);
		rdchk(A_CN, 32'h0);
		u_cpu.tick(1);
		rdchk(A_CN, 32'hFFFFFF);
		tmo(32'h1, 1'b0, 1, 0, 0, 32'h20);
		tmo(32'h3, 1'b0, 0, 1, 0, 32'h20);
		tmo(32'h3, 1'b1, 0, 0, 1, 32'h60);
		tmo(32'h1, 1'b1, 1, 0, 1, 32'h60);
		unlock();
		apb(1'b1, A_CS, 32'h81);
		rdchk(A_CS, 32'h01);
		u_cpu.refresh();
		u_cpu.tick(2);
		rdchk(A_CN, {24'h0, l});
		u_cpu.mode(1'b0, 1'b0, 1'b0);
		u_cpu.tick(2);
		rdchk(A_CN, {24'h0, l} - 32'h2);
		unlock();
		apb(1'b1, A_CS, 32'h00);
		rdchk(A_CS, 32'h00);
		u_cpu.mode(1'b0, 1'b1, 1'b1);
		u_cpu.tick(1);
		rdchk(A_CN, {24'h0, l} - 32'h3);
		rdchk(A_CS, 32'h10);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rdchk(A_CN, 32'hFFFFFF);
		rdchk(A_CS, 32'h80);
		apb(1'b1, A_OP, 32'h1);
		rdchk(A_CN, {8'h0, watchdog_pkg::RELOAD_RESET});
		tally_and_finish();
	end
endmodule
